// ===== pkg/sdp_map.svh
// constants for the serial descriptor / hid programming port
`ifndef SDP_MAP_SVH
`define SDP_MAP_SVH

// command word geometry
`define SDP_WORD_BITS 16
`define SDP_FSEL_BIT 11
`define SDP_RELOAD_BIT 9
`define SDP_DATA_MSB 7

// descriptor image size
`define SDP_DESC_BITS 456
`define SDP_DESC_BYTES (`SDP_DESC_BITS / 8)

// descriptor byte layout, byte index of each field
`define SDP_OFS_VENDOR_ID 0
`define SDP_OFS_PRODUCT_ID 2
`define SDP_OFS_PRODUCT_STR 4
`define SDP_OFS_VENDOR_STR 20
`define SDP_OFS_PWR_ATTR 52
`define SDP_OFS_MAX_PWR 53
`define SDP_OFS_HID_AUX 54

// reset values
`define SDP_HID_RESET 8'h00
`define SDP_BYTE_RESET 8'h00

`endif

// ===== pkg/sdp_pkg.sv
// types shared by the serial descriptor / hid programming port
`default_nettype none
package sdp_pkg;

   // one received command word, first bit sent sits at the top
   typedef struct packed {
      logic [3:0] zero_hi;      // always zero
      logic function_select;    // 0 hid status, 1 descriptor data
      logic zero_b10;           // always zero
      logic reload_start;       // restart descriptor load
      logic zero_b8;            // always zero
      logic [7:0] data_sent;    // d0 first in time, so d0 at bit 7
   } sdp_word_s;

   // one descriptor byte write into the store
   typedef struct packed {
      logic [5:0] addr;         // byte index
      logic [7:0] data;         // byte value, bit 0 lsb
   } sdp_desc_wr_s;

   // descriptor load progress
   typedef enum logic [1:0] {
      SDP_IDLE,
      SDP_LOADING,
      SDP_DONE
   } sdp_load_e;

endpackage
`default_nettype wire

// ===== src/sdp_link_shifter.sv
// shift register on the serial shift clock, one word per frame
`timescale 1ns/10ps
`default_nettype none
`include "sdp_map.svh"
module sdp_link_shifter
#(
   parameter int WORD_BITS = `SDP_WORD_BITS
)
(
   // link clock and reset
   input wire logic serial_shift_clock,
   input wire logic reset,
   // link pins, already in this clock's timing
   input wire logic word_frame_strobe,
   input wire logic serial_data_in,
   // captured word and completion toggle
   output logic [WORD_BITS-1:0] word_r,
   output logic done_tgl_r
);

   localparam int CW = $clog2(WORD_BITS + 1);
   localparam logic [CW-1:0] LAST = CW'(WORD_BITS - 1);

   logic [CW-1:0] cnt_r;   // bits taken this frame
   logic frame_clr;        // strobe high clears the count
   logic take;             // this edge still belongs to the word
   logic last_bit;         // this edge completes the word

   // the clock stops between frames, so the strobe itself ends the frame
   assign frame_clr = reset | word_frame_strobe;
   assign take = (cnt_r <= LAST);
   assign last_bit = (cnt_r == LAST);

   // bit counter, saturates so extra bits are ignored
   always_ff @(posedge serial_shift_clock or posedge frame_clr)
   begin
      if (frame_clr)
         cnt_r <= '0;
      else if (take)
         cnt_r <= cnt_r + CW'(1);
   end

   // data sampled on rising edges, first bit ends at the top
   always_ff @(posedge serial_shift_clock or posedge reset)
   begin
      if (reset)
         word_r <= '0;
      else if (take)
         word_r <= {word_r[WORD_BITS-2:0], serial_data_in};
   end

   // toggle once per complete word; word_r then holds until the next frame
   always_ff @(posedge serial_shift_clock or posedge reset)
   begin
      if (reset)
         done_tgl_r <= 1'b0;
      else if (last_bit)
         done_tgl_r <= ~done_tgl_r;
   end

endmodule // sdp_link_shifter
`default_nettype wire

// ===== src/sdp_sync.sv
// two flip-flop level synchroniser, any width
`timescale 1ns/10ps
`default_nettype none
module sdp_sync
#(
   parameter int WIDTH = 1
)
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // levels from another domain
   input wire logic [WIDTH-1:0] async_in,
   // levels safe to use
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_r; // first stage, read only by second stage

   // each bit crosses independently; callers must not rely on bits arriving together
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         meta_r <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end

endmodule // sdp_sync
`default_nettype wire

// ===== src/sdp_top.sv
// serial command port: hid button status and descriptor store loading
`timescale 1ns/10ps
`default_nettype none
`include "sdp_map.svh"
//
// How it works
// - word bit 11 selects hid or descriptor
// - hid write drives eight active-high buttons
// - descriptor write stores byte, bit0 lsb
// - reload bit clears address, starts loading
// - reload only with select low, also hid
// - select low always updates hid status
// - loading needs both power and override pins
// - fixed descriptor byte order and sizes
// - no loading when self-powered
//
module sdp_top
   import sdp_pkg::*;
#(
   parameter int WORD_BITS = `SDP_WORD_BITS,
   parameter int DESC_BYTES = `SDP_DESC_BYTES
)
(
   // system clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // serial link
   input wire logic serial_shift_clock,
   input wire logic word_frame_strobe,
   input wire logic serial_data_in,
   // configuration pins
   input wire logic power_source_select,
   input wire logic descriptor_override,
   // descriptor read port for the usb side
   input wire logic [5:0] desc_rd_addr,
   output logic [7:0] desc_rd_data_r,
   // hid status to the usb side
   output logic [7:0] hid_buttons_r,
   output logic hid_update_r,
   // descriptor load status
   output logic desc_loading_r,
   output logic desc_done_r,
   output logic [5:0] desc_count_r,
   output logic [7:0] desc_pwr_attr_r,
   output logic [7:0] desc_max_pwr_r
);

   ////////////////////////////////////////////////////////////////////////////
   // constants

   localparam logic [5:0] LAST_ADDR = 6'(DESC_BYTES - 1);    // final byte index
   localparam logic [5:0] PWR_ATTR_ADDR = 6'(`SDP_OFS_PWR_ATTR); // power attribute
   localparam logic [5:0] MAX_PWR_ADDR = 6'(`SDP_OFS_MAX_PWR);   // maximum power

   ////////////////////////////////////////////////////////////////////////////
   // link domain

   logic [WORD_BITS-1:0] link_word; // word held on the link side
   logic link_tgl;                  // flips once per complete word

   // shift register runs entirely on the host's clock
   sdp_link_shifter #(
      .WORD_BITS(WORD_BITS)
   ) u_shift (
      .serial_shift_clock(serial_shift_clock),
      .reset(reset),
      .word_frame_strobe(word_frame_strobe),
      .serial_data_in(serial_data_in),
      .word_r(link_word),
      .done_tgl_r(link_tgl)
   );

   ////////////////////////////////////////////////////////////////////////////
   // crossings into the system domain

   logic [3:0] sync_raw;  // levels from pins and the link
   logic [3:0] sync_lvl;  // synchronised copies
   logic tgl_s;           // word toggle
   logic strobe_s;        // frame strobe
   logic psel_s;          // power source select
   logic ovr_s;           // descriptor override

   assign sync_raw = {link_tgl, word_frame_strobe, power_source_select, descriptor_override};
   assign tgl_s = sync_lvl[3];
   assign strobe_s = sync_lvl[2];
   assign psel_s = sync_lvl[1];
   assign ovr_s = sync_lvl[0];

   // all four are plain levels, two flops each
   sdp_sync #(
      .WIDTH(4)
   ) u_sync (
      .clk(sys_clk),
      .reset(reset),
      .async_in(sync_raw),
      .sync_out(sync_lvl)
   );

   ////////////////////////////////////////////////////////////////////////////
   // word capture

   logic tgl_d_r;          // previous toggle level
   logic tgl_edge;         // a new word has finished shifting
   logic pend_r;           // word captured, waiting for frame end
   logic pend_nxt;
   logic act;              // act on the held word now
   sdp_word_s word_r;      // word copied into this domain

   assign tgl_edge = tgl_s ^ tgl_d_r;
   // the word is acted on only once the strobe is back high
   assign act = pend_r & strobe_s;
   // a new word wins over the clearing of the old one
   assign pend_nxt = tgl_edge ? 1'b1 : (act ? 1'b0 : pend_r);

   // the link word stands still from its last bit to the next frame,
   // so copying it after the synchronised toggle is safe
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         tgl_d_r <= 1'b0;
         pend_r <= 1'b0;
         word_r <= '0;
      end
      else
      begin
         tgl_d_r <= tgl_s;
         pend_r <= pend_nxt;
         if (tgl_edge)
            word_r <= sdp_word_s'(link_word);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // decode

   logic [7:0] low_byte;   // low byte with d0 at bit 0
   logic fsel;             // function select
   logic reload;           // reload start
   logic prog_ok;          // pins allow descriptor loading
   logic hid_wr;           // hid status write
   logic reload_go;        // address reset
   logic reserved;         // both bits set
   logic desc_wr;          // descriptor byte write accepted
   sdp_desc_wr_s wr;       // write into the store
   sdp_load_e state_r;     // load progress, read by the byte gate below
   sdp_load_e state_nxt;

   // d0 arrives first and lands at bit 7, so turn the byte round
   genvar gi;
   generate
      for (gi = 0; gi <= `SDP_DATA_MSB; gi++)
      begin : g_rev
         assign low_byte[gi] = word_r.data_sent[`SDP_DATA_MSB - gi];
      end
   endgenerate

   assign fsel = word_r.function_select;
   assign reload = word_r.reload_start;
   // both pins high; self-powered setup never loads
   assign prog_ok = psel_s & ovr_s;
   // select low is always an hid write, reload or not
   assign hid_wr = act & ~fsel;
   // reload with select low also restarts the address
   assign reload_go = act & ~fsel & reload;
   // select and reload together do nothing at all
   assign reserved = fsel & reload;
   // bytes only while a load is running and space remains
   assign desc_wr = act & fsel & ~reserved & prog_ok & (state_r == SDP_LOADING);
   assign wr.addr = desc_count_r;
   assign wr.data = low_byte;

   ////////////////////////////////////////////////////////////////////////////
   // load state machine

   // loading ends after the full image; an hid word without reload or lost pins abandon it
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         SDP_IDLE:
         begin
            if (reload_go & prog_ok)
               state_nxt = SDP_LOADING;
         end
         SDP_LOADING:
         begin
            if (~prog_ok)
               state_nxt = SDP_IDLE;
            else if (reload_go)
               state_nxt = SDP_LOADING;
            else if (hid_wr)
               state_nxt = SDP_IDLE;      // broken image, host must reload
            else if (desc_wr & (desc_count_r == LAST_ADDR))
               state_nxt = SDP_DONE;
         end
         SDP_DONE:
         begin
            if (reload_go & prog_ok)
               state_nxt = SDP_LOADING;
         end
         default:
         begin
            state_nxt = SDP_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         state_r <= SDP_IDLE;
      else
         state_r <= state_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////
   // address counter and status

   logic [5:0] count_nxt;  // next byte index

   // the reset of the address happens even when loading is not allowed
   assign count_nxt = reload_go ? 6'h00 : (desc_wr ? desc_count_r + 6'h01 : desc_count_r);

   // counter and load flags
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         desc_count_r <= 6'h00;
         desc_loading_r <= 1'b0;
         desc_done_r <= 1'b0;
      end
      else
      begin
         desc_count_r <= count_nxt;
         desc_loading_r <= (state_nxt == SDP_LOADING);
         desc_done_r <= (state_nxt == SDP_DONE);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // hid status

   // buttons hold their last reported state; update pulses one cycle
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         hid_buttons_r <= `SDP_HID_RESET;
         hid_update_r <= 1'b0;
      end
      else
      begin
         hid_update_r <= hid_wr;
         if (hid_wr)
            hid_buttons_r <= low_byte;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // descriptor store

   logic [7:0] store_r [DESC_BYTES];  // one flop byte per descriptor byte
   logic [7:0] rd_byte;               // selected read byte

   // out of range reads give zero instead of an undefined index
   assign rd_byte = (desc_rd_addr <= LAST_ADDR) ? store_r[desc_rd_addr] : 8'h00;

   // byte index follows the fixed field order of the image
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         for (int i = 0; i < DESC_BYTES; i++)
            store_r[i] <= `SDP_BYTE_RESET;
      end
      else if (desc_wr)
      begin
         store_r[wr.addr] <= wr.data;
      end
   end

   // registered read port
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         desc_rd_data_r <= 8'h00;
      else
         desc_rd_data_r <= rd_byte;
   end

   ////////////////////////////////////////////////////////////////////////////
   // power fields

   logic pwr_attr_hit;   // write lands on the power attribute
   logic max_pwr_hit;    // write lands on the maximum power

   // no check of the values: keeping them consistent is the host's job
   assign pwr_attr_hit = desc_wr & (wr.addr == PWR_ATTR_ADDR);
   assign max_pwr_hit = desc_wr & (wr.addr == MAX_PWR_ADDR);

   // shadow copies so the usb side can see them without a read cycle
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         desc_pwr_attr_r <= `SDP_BYTE_RESET;
         desc_max_pwr_r <= `SDP_BYTE_RESET;
      end
      else
      begin
         if (pwr_attr_hit)
            desc_pwr_attr_r <= wr.data;
         if (max_pwr_hit)
            desc_max_pwr_r <= wr.data;
      end
   end

endmodule // sdp_top
`default_nettype wire

// ===== tb/sdp_host_model.sv
// serial host model: frames one command word on the link pins
`timescale 1ns/10ps
`default_nettype none
module sdp_host_model
(
   // link pins toward the device
   output logic serial_shift_clock,
   output logic word_frame_strobe,
   output logic serial_data_in
);
   logic dplus_pullup; // host-owned d+ pull-up, off until the image is loaded
   ////////////////////////////////////////
   // idle levels before the first word
   initial
   begin
      serial_shift_clock = 1'b0; // clock stands still outside frames
      word_frame_strobe = 1'b1;
      serial_data_in = 1'b0;
      dplus_pullup = 1'b0;
   end
   // top bit first in time; odd lead-in keeps link edges off the system grid
   task automatic send_word(input logic [15:0] w);
      word_frame_strobe = 1'b0;
      #21.3;
      for (int i = 15; i >= 0; i--)
      begin
         serial_data_in = w[i];
         #16 serial_shift_clock = 1'b1;
         #16 serial_shift_clock = 1'b0;
      end
      // hold time over: show the inverse, not the stale bit
      serial_data_in = ~serial_data_in;
      #20 word_frame_strobe = 1'b1;
      #120;
   endtask
   // pull-up may come on only once the device reports a full image
   task automatic attach(input logic loaded);
      dplus_pullup = loaded;
   endtask
endmodule // sdp_host_model
`default_nettype wire

// ===== tb/sdp_top_sva.sv
// concurrent checks on the serial command port outputs
`timescale 1ns/10ps
`default_nettype none
`include "sdp_map.svh"
module sdp_top_sva
#(
   parameter int WORD_BITS = 16,
   parameter int DESC_BYTES = 57
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // pins and read port
   input wire logic power_source_select,
   input wire logic descriptor_override,
   input wire logic [5:0] desc_rd_addr,
   input wire logic [7:0] desc_rd_data_r,
   // status outputs
   input wire logic [7:0] hid_buttons_r,
   input wire logic hid_update_r,
   input wire logic desc_loading_r,
   input wire logic desc_done_r,
   input wire logic [5:0] desc_count_r,
   input wire logic [7:0] desc_pwr_attr_r,
   input wire logic [7:0] desc_max_pwr_r
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   ////////////////////////////////////////
   // a store byte landed: count changed to a nonzero value
   sequence byte_landed;
      $changed(desc_count_r) && desc_count_r != 6'h00;
   endsequence
   hid_pulse_a:
      assert property (hid_update_r |=> !hid_update_r)
      else $error("hid update pulse too long");
   hid_cause_a:
      assert property ($changed(hid_buttons_r) |-> hid_update_r)
      else $error("buttons changed without update");
   count_step_a:
      assert property (byte_landed |-> desc_count_r == $past(desc_count_r) + 6'h01)
      else $error("byte count skipped");
   count_max_a:
      assert property (desc_count_r <= 6'(DESC_BYTES))
      else $error("byte count past image size");
   pin_gate_a:
      assert property (byte_landed |-> $past(power_source_select, 3) && $past(descriptor_override, 3))
      else $error("byte stored with pins low");
   done_full_a:
      assert property ($rose(desc_done_r) |-> desc_count_r == 6'(DESC_BYTES) && !desc_loading_r)
      else $error("done without full image");
   state_excl_a:
      assert property (!(desc_loading_r && desc_done_r))
      else $error("loading and done together");
   load_start_a:
      assert property ($rose(desc_loading_r) |-> desc_count_r == 6'h00)
      else $error("load began with count set");
   pwr_copy_a:
      assert property ($changed(desc_pwr_attr_r) |-> desc_count_r == 6'(`SDP_OFS_PWR_ATTR + 1))
      else $error("power attribute from wrong byte");
   maxp_copy_a:
      assert property ($changed(desc_max_pwr_r) |-> desc_count_r == 6'(`SDP_OFS_MAX_PWR + 1))
      else $error("max power from wrong byte");
   rd_zero_a:
      assert property (desc_rd_addr > 6'h38 |=> desc_rd_data_r == 8'h00)
      else $error("read past store not zero");
endmodule // sdp_top_sva
bind sdp_top sdp_top_sva #(.WORD_BITS(WORD_BITS), .DESC_BYTES(DESC_BYTES)) u_sva (
   .sys_clk(sys_clk), .reset(reset), .power_source_select(power_source_select),
   .descriptor_override(descriptor_override), .desc_rd_addr(desc_rd_addr),
   .desc_rd_data_r(desc_rd_data_r), .hid_buttons_r(hid_buttons_r), .hid_update_r(hid_update_r),
   .desc_loading_r(desc_loading_r), .desc_done_r(desc_done_r), .desc_count_r(desc_count_r),
   .desc_pwr_attr_r(desc_pwr_attr_r), .desc_max_pwr_r(desc_max_pwr_r));
`default_nettype wire

// ===== tb/sdp_top_tb.sv
// bench for the serial command port
`timescale 1ns/10ps
`default_nettype none
`include "sdp_map.svh"
module sdp_top_tb;
   import sdp_pkg::*;
   ////////////////////////////////////////
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic pss = 1'b1; // bus powered
   logic ovr = 1'b1; // override allowed
   logic [5:0] desc_rd_addr = 6'h00;
   wire logic sclk, strobe, sdata; // from host model
   logic [7:0] rd_data, hid, pwr, maxp;
   logic hid_upd, loading, done;
   logic [5:0] cnt;
   int num_errors = 0;
   int compares = 0;
   int upd_seen = 0; // hid update pulses seen
   always #2 sys_clk = ~sys_clk;
   // one-cycle pulse, looked at mid-cycle where it has settled
   always @(negedge sys_clk)
   begin
      if (hid_upd === 1'b1)
         upd_seen++;
   end
   sdp_host_model u_host (.serial_shift_clock(sclk), .word_frame_strobe(strobe), .serial_data_in(sdata));
   sdp_top u_dut (.sys_clk(sys_clk), .reset(reset), .serial_shift_clock(sclk), .word_frame_strobe(strobe),
      .serial_data_in(sdata), .power_source_select(pss), .descriptor_override(ovr),
      .desc_rd_addr(desc_rd_addr), .desc_rd_data_r(rd_data), .hid_buttons_r(hid), .hid_update_r(hid_upd),
      .desc_loading_r(loading), .desc_done_r(done), .desc_count_r(cnt), .desc_pwr_attr_r(pwr),
      .desc_max_pwr_r(maxp));
   ////////////////////////////////////////
   // compare and count
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp)
      begin
         num_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   // build a word; low byte goes d0 first
   function automatic logic [15:0] cmd(input logic fsel, input logic rld, input logic [7:0] b);
      sdp_word_s w;
      w = '0;
      w.function_select = fsel;
      w.reload_start = rld;
      w.data_sent = {<<{b}};
      return w;
   endfunction
   // image bytes; power fields kept consistent with bus power
   function automatic logic [7:0] dbyte(input int n);
      if (n == `SDP_OFS_PWR_ATTR)
         return 8'h80;
      if (n == `SDP_OFS_MAX_PWR)
         return 8'h7D;
      return 8'(n * 37 + 5);
   endfunction
   // one word on the link, settled before return
   task automatic send(input logic fsel, input logic rld, input logic [7:0] b);
      @(posedge sys_clk);
      #1 u_host.send_word(cmd(fsel, rld, b));
   endtask
   task automatic final_report;
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   ////////////////////////////////////////
   // hang guard
   initial
   begin
      #150000;
      num_errors++;
      final_report;
   end
   initial
   begin
      repeat (20) @(posedge sys_clk);
      #1 reset = 1'b0;
      repeat (6) @(posedge sys_clk);
      check("hid", 8'h00, hid);
      for (int i = 0; i < 8; i++)
      begin
         send(1'b0, 1'b0, 8'h01 << i);
         check("hid", 8'h01 << i, hid);
      end
      send(1'b0, 1'b1, 8'hA5);
      check("hid", 8'hA5, hid);
      check("loading", 8'h01, {7'h00, loading});
      send(1'b1, 1'b1, 8'h3C);
      check("hid", 8'hA5, hid);
      check("count", 8'h00, {2'b00, cnt});
      check("updates", 8'h09, 8'(upd_seen));
      for (int n = 0; n < 57; n++)
         send(1'b1, 1'b0, dbyte(n));
      send(1'b1, 1'b0, 8'hFF);
      check("count", 8'h39, {2'b00, cnt});
      check("done", 8'h01, {7'h00, done});
      check("pwr", 8'h80, pwr);
      check("maxp", 8'h7D, maxp);
      u_host.attach(done);
      for (int a = 0; a < 59; a++)
      begin
         @(posedge sys_clk);
         #1 desc_rd_addr = 6'(a);
         @(posedge sys_clk);
         #1 check("store", (a < 57) ? dbyte(a) : 8'h00, rd_data);
      end
      for (int k = 0; k < 2; k++)
      begin
         send(1'b0, 1'b1, 8'h0F);
         check("loading", 8'h01, {7'h00, loading});
         @(posedge sys_clk);
         #1 pss = 1'(k);
         ovr = 1'(1 - k);
         send(1'b1, 1'b0, 8'h77);
         check("count", 8'h00, {2'b00, cnt});
         send(1'b0, 1'b1, 8'h0F);
         check("loading", 8'h00, {7'h00, loading});
         @(posedge sys_clk);
         #1 pss = 1'b1;
         ovr = 1'b1;
      end
      check("updates", 8'h0D, 8'(upd_seen));
      final_report;
   end
endmodule // sdp_top_tb
`default_nettype wire
